// ---- shared/otm_pkg.sv ----
// Constants, register map and types of the output terminal mapper
package otm_pkg;
    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS = 32'h0000_000a;
    localparam int unsigned CLK_HZ = 32'h05f5_e100;
    localparam int unsigned PULSE_UNIT_HZ = 32'h0000_000a;
    localparam int unsigned NS_PER_MS = 32'h000f_4240;
    localparam int unsigned DELAY_UNIT_MS = 32'h0000_0064;
    localparam int unsigned TICK_CYCLES = DELAY_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam logic [23:0] NCO_MOD = 24'(CLK_HZ / PULSE_UNIT_HZ);
    localparam logic [23:0] NCO_HALF = 24'(CLK_HZ / PULSE_UNIT_HZ / 2);

    // Scaling figures
    localparam logic [9:0] PCT_FULL = 10'h3e8;
    localparam logic [31:0] PCT_SCALE = 32'h0000_03e8;
    localparam logic [31:0] FIXED_FS = 32'h0000_2710;
    localparam logic [31:0] VOLT_NUM = 32'h0000_000c;
    localparam logic [31:0] VOLT_DEN = 32'h0000_000a;
    localparam logic [31:0] GAIN_UNIT = 32'h0000_0064;

    // Source-select codes
    localparam logic [4:0] SRC_COMM = 5'h0c;
    localparam logic [4:0] SRC_MAX = 5'h10;
    localparam int unsigned SRC_N = 17;

    // Register byte offsets
    localparam logic [11:0] OFS_PULSE_SEL = 12'h000;
    localparam logic [11:0] OFS_A1_SEL = 12'h004;
    localparam logic [11:0] OFS_A2_SEL = 12'h008;
    localparam logic [11:0] OFS_MAXF = 12'h00c;
    localparam logic [11:0] OFS_A1_OFF = 12'h010;
    localparam logic [11:0] OFS_A1_GAIN = 12'h014;
    localparam logic [11:0] OFS_A2_OFF = 12'h018;
    localparam logic [11:0] OFS_A2_GAIN = 12'h01c;
    localparam logic [11:0] OFS_DELAY0 = 12'h020;
    localparam logic [11:0] OFS_POL = 12'h034;
    localparam logic [11:0] OFS_TERM = 12'h038;
    localparam logic [11:0] OFS_FREQ = 12'h03c;
    localparam logic [11:0] OFS_ANA = 12'h040;
    localparam int unsigned DOUT_N = 5;
    localparam int unsigned POL_DIGIT_W = 4;
    localparam int unsigned ANA2_POS = 16;

    // Reset values and limits
    localparam logic [4:0] PULSE_SEL_RST = 5'h00;
    localparam logic [4:0] A1_SEL_RST = 5'h00;
    localparam logic [4:0] A2_SEL_RST = 5'h01;
    localparam logic [13:0] MAXF_RST = 14'h1388;
    localparam logic [13:0] MAXF_MIN = 14'h0001;
    localparam logic [13:0] MAXF_MAX = 14'h2710;
    localparam logic [15:0] GAIN_RST = 16'h0064;
    localparam logic [15:0] GAIN_LIM = 16'h03e8;
    localparam logic [15:0] OFF_RST = 16'h0000;
    localparam logic [15:0] OFF_LIM = 16'h03e8;
    localparam logic [15:0] DELAY_RST = 16'h0000;
    localparam logic [15:0] DELAY_MAX = 16'h8ca0;
    localparam logic [4:0] POL_RST = 5'h00;

    typedef logic [9:0] otm_pct_t;
    typedef logic [15:0] otm_qty_t;
    typedef logic [31:0] otm_word_t;

    // Per-channel delay state
    typedef enum logic [1:0] {
        OTM_IDLE = 2'b01,
        OTM_WAIT = 2'b10
    } otm_dstate_e;
endpackage : otm_pkg

// ---- shared/otm_if.sv ----
// Links between the mapper core and its analog and digital output stages
`timescale 1ns/1ps
interface otm_if;
    logic [1:0][9:0] x;
    logic [1:0][15:0] gain;
    logic [1:0][15:0] offset;
    logic [1:0][9:0] y;
    logic [4:0] status;
    logic [4:0] polarity;
    logic [4:0][15:0] delay;
    logic [4:0] terminal;
    modport ctrl(output x, gain, offset, status, polarity, delay, input y, terminal);
    modport ana(input x, gain, offset, output y);
    modport dig(input status, polarity, delay, output terminal);
endinterface : otm_if

// ---- src/otm_scale.sv ----
// Gain, offset and clamp stage of both analog outputs
`timescale 1ns/1ps
module otm_scale (
    input logic pclk,
    input logic presetn,
    otm_if.ana bus
);
    import otm_pkg::*;

    typedef struct packed {
        logic [1:0][9:0] y;
    } otm_scale_s;

    otm_scale_s s;
    otm_scale_s next_s;

    // Y = k * X + b per channel, limited to the output range
    always_comb begin
        logic signed [31:0] prod;
        logic signed [31:0] v;
        prod = 32'sh0;
        v = 32'sh0;
        next_s = s;
        for (int i = 0; i < 2; i++) begin
            prod = 32'($signed(bus.gain[i])) * $signed({22'h0, bus.x[i]});
            v = prod / $signed(GAIN_UNIT) + 32'($signed(bus.offset[i]));
            if (v < 32'sh0) begin
                next_s.y[i] = 10'h000;
            end else if (v > $signed({22'h0, PCT_FULL})) begin
                next_s.y[i] = PCT_FULL;
            end else begin
                next_s.y[i] = v[9:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bus.y = s.y;
endmodule : otm_scale

// ---- src/otm_dout.sv ----
// Delay and polarity stage of the five digital output terminals
`timescale 1ns/1ps
module otm_dout #(
    parameter int unsigned TICK = otm_pkg::TICK_CYCLES
) (
    input logic pclk,
    input logic presetn,
    otm_if.dig bus
);
    import otm_pkg::*;

    typedef struct packed {
        otm_dstate_e st;
        logic applied;
        logic [15:0] cnt;
        logic [23:0] pre;
    } otm_dch_s;

    typedef struct packed {
        otm_dch_s [4:0] ch;
        logic [4:0] terminal;
    } otm_dout_s;

    localparam logic [23:0] TICK_LAST = 24'(TICK - 1);

    otm_dout_s s;
    otm_dout_s next_s;

    // Each channel times its own change; a prescaler per channel keeps the delay exact
    always_comb begin
        next_s = s;
        for (int i = 0; i < DOUT_N; i++) begin
            case (s.ch[i].st)
                OTM_IDLE: begin
                    if (bus.status[i] != s.ch[i].applied) begin
                        if (bus.delay[i] == 16'h0000) begin
                            next_s.ch[i].applied = bus.status[i];
                        end else begin
                            next_s.ch[i].st = OTM_WAIT;
                            next_s.ch[i].cnt = 16'h0000;
                            next_s.ch[i].pre = 24'h000000;
                        end
                    end
                end
                OTM_WAIT: begin
                    if (bus.status[i] == s.ch[i].applied) begin
                        next_s.ch[i].st = OTM_IDLE;
                    end else if (s.ch[i].pre == TICK_LAST) begin
                        next_s.ch[i].pre = 24'h000000;
                        next_s.ch[i].cnt = s.ch[i].cnt + 16'h0001;
                        // A delay shortened while waiting ends the wait at the next tick
                        if ((s.ch[i].cnt + 16'h0001) >= bus.delay[i]) begin
                            next_s.ch[i].applied = bus.status[i];
                            next_s.ch[i].st = OTM_IDLE;
                        end
                    end else begin
                        next_s.ch[i].pre = s.ch[i].pre + 24'h000001;
                    end
                end
                default: begin
                    next_s.ch[i].st = OTM_IDLE;
                end
            endcase
            // High means terminal closed to common_return
            next_s.terminal[i] = next_s.ch[i].applied ^ bus.polarity[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DOUT_N; i++) begin
                s.ch[i].st <= OTM_IDLE;
                s.ch[i].applied <= 1'b0;
                s.ch[i].cnt <= 16'h0000;
                s.ch[i].pre <= 24'h000000;
            end
            s.terminal <= 5'h00;
        end else begin
            s <= next_s;
        end
    end

    assign bus.terminal = s.terminal;
endmodule : otm_dout

// ---- src/otm_top.sv ----
// Output terminal mapper: APB registers, source scaling and pulse generator
`timescale 1ns/1ps
module otm_top #(
    parameter int unsigned TICK_CYCLES = otm_pkg::TICK_CYCLES
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input otm_pkg::otm_word_t pwdata,
    input logic [3:0] pstrb,
    output otm_pkg::otm_word_t prdata,
    output logic pready,
    output logic pslverr,
    input otm_pkg::otm_qty_t run_freq,
    input otm_pkg::otm_qty_t set_freq,
    input otm_pkg::otm_qty_t max_out_freq,
    input otm_pkg::otm_qty_t out_current,
    input otm_pkg::otm_qty_t rated_current,
    input otm_pkg::otm_qty_t abs_torque,
    input otm_pkg::otm_qty_t rated_torque,
    input otm_pkg::otm_qty_t out_power,
    input otm_pkg::otm_qty_t rated_power,
    input otm_pkg::otm_qty_t out_voltage,
    input otm_pkg::otm_qty_t rated_voltage,
    input otm_pkg::otm_qty_t pulse_in_freq,
    input otm_pkg::otm_qty_t analog_in_1,
    input otm_pkg::otm_qty_t analog_in_2,
    input otm_pkg::otm_qty_t analog_in_3,
    input otm_pkg::otm_qty_t length_value,
    input otm_pkg::otm_qty_t max_length,
    input otm_pkg::otm_qty_t count_value,
    input otm_pkg::otm_qty_t max_count,
    input otm_pkg::otm_qty_t comm_permille,
    input otm_pkg::otm_qty_t motor_speed,
    input otm_pkg::otm_qty_t max_speed,
    input otm_pkg::otm_qty_t current_deciamp,
    input otm_pkg::otm_qty_t voltage_level,
    input otm_pkg::otm_qty_t actual_torque,
    input logic [4:0] terminal_status,
    output logic pulse_freq_output,
    output otm_pkg::otm_pct_t analog_out_1,
    output otm_pkg::otm_pct_t analog_out_2,
    output logic multi_terminal_digital_output,
    output logic relay_1_output,
    output logic relay_2_output,
    output logic digital_out_1,
    output logic digital_out_2
);
    import otm_pkg::*;

    typedef struct packed {
        logic [2:0][4:0] sel;
        logic [13:0] maxf;
        logic [1:0][15:0] off;
        logic [1:0][15:0] gain;
        logic [4:0][15:0] delay;
        logic [4:0] pol;
        logic [2:0][9:0] pct;
        logic [13:0] freq;
        logic [23:0] acc;
        logic pulse;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } otm_top_s;

    otm_top_s s;
    otm_top_s next_s;
    otm_if bus ();
    logic [SRC_N-1:0][9:0] src;
    logic signed [32:0] tq_shift;
    logic [31:0] tq_pos;

    // Quantity against its full scale, in tenths of a percent
    function automatic otm_pct_t pct(input logic [31:0] q, input logic [31:0] fs);
        logic [31:0] r;
        r = 32'h0;
        if (fs == 32'h0) begin
            r = 32'h0;
        end else if (q >= fs) begin
            r = {22'h0, PCT_FULL};
        end else begin
            r = (q * PCT_SCALE) / fs;
        end
        return r[9:0];
    endfunction : pct

    // Byte-lane merge of an APB write into the old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // Signed setting held to plus or minus a limit
    function automatic logic [15:0] clamp_s(input logic [15:0] v, input logic [15:0] lim);
        logic [15:0] r;
        r = v;
        if ($signed(v) > $signed(lim)) begin
            r = lim;
        end else if ($signed(v) < -$signed(lim)) begin
            r = 16'(-$signed(lim));
        end
        return r;
    endfunction : clamp_s

    function automatic logic [31:0] sext(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction : sext

    function automatic logic addr_ok(input logic [11:0] a);
        return (a[1:0] == 2'b00) && (a <= OFS_ANA);
    endfunction : addr_ok

    // Signed torque shifted by twice rated so the span starts at zero
    assign tq_shift = $signed({{17{actual_torque[15]}}, actual_torque})
                      + $signed({16'h0, rated_torque, 1'b0});
    assign tq_pos = tq_shift[32] ? 32'h0 : tq_shift[31:0];

    // Source table, one entry per select code
    assign src[0] = pct(32'(run_freq), 32'(max_out_freq));
    assign src[1] = pct(32'(set_freq), 32'(max_out_freq));
    assign src[2] = pct(32'(out_current), {15'h0, rated_current, 1'b0});
    assign src[3] = pct(32'(abs_torque), {15'h0, rated_torque, 1'b0});
    assign src[4] = pct(32'(out_power), {15'h0, rated_power, 1'b0});
    assign src[5] = pct(32'(out_voltage) * VOLT_DEN, 32'(rated_voltage) * VOLT_NUM);
    assign src[6] = pct(32'(pulse_in_freq), FIXED_FS);
    assign src[7] = pct(32'(analog_in_1), FIXED_FS);
    assign src[8] = pct(32'(analog_in_2), FIXED_FS);
    assign src[9] = pct(32'(analog_in_3), FIXED_FS);
    assign src[10] = pct(32'(length_value), 32'(max_length));
    assign src[11] = pct(32'(count_value), 32'(max_count));
    assign src[SRC_COMM] = pct(32'(comm_permille), PCT_SCALE);
    assign src[13] = pct(32'(motor_speed), 32'(max_speed));
    assign src[14] = pct(32'(current_deciamp), FIXED_FS);
    assign src[15] = pct(32'(voltage_level), FIXED_FS);
    assign src[SRC_MAX] = pct(tq_pos, {14'h0, rated_torque, 2'b00});

    // Register file, scaling and pulse oscillator in one next-state pass
    always_comb begin
        logic [31:0] w;
        logic [31:0] rd;
        logic [31:0] span;
        logic [24:0] sum;
        logic setup;
        logic wr;
        w = 32'h0;
        rd = 32'h0;
        span = 32'h0;
        sum = 25'h0;
        setup = psel & ~penable;
        wr = psel & penable & s.pready & pwrite & ~s.pslverr;
        next_s = s;
        // Answer prepared in setup, presented in the first access cycle
        case (paddr)
            OFS_PULSE_SEL: rd = {27'h0, s.sel[0]};
            OFS_A1_SEL: rd = {27'h0, s.sel[1]};
            OFS_A2_SEL: rd = {27'h0, s.sel[2]};
            OFS_MAXF: rd = {18'h0, s.maxf};
            OFS_A1_OFF: rd = sext(s.off[0]);
            OFS_A1_GAIN: rd = sext(s.gain[0]);
            OFS_A2_OFF: rd = sext(s.off[1]);
            OFS_A2_GAIN: rd = sext(s.gain[1]);
            OFS_POL: begin
                for (int i = 0; i < DOUT_N; i++) begin
                    rd[POL_DIGIT_W*i] = s.pol[i];
                end
            end
            OFS_TERM: rd = {27'h0, bus.terminal};
            OFS_FREQ: rd = {18'h0, s.freq};
            OFS_ANA: rd = {6'h0, bus.y[1], 6'h0, bus.y[0]};
            default: begin
                for (int i = 0; i < DOUT_N; i++) begin
                    if (paddr == OFS_DELAY0 + 12'(4 * i)) begin
                        rd = {16'h0, s.delay[i]};
                    end
                end
            end
        endcase
        next_s.pready = setup;
        next_s.pslverr = setup & ~addr_ok(paddr);
        next_s.prdata = (setup & addr_ok(paddr) & ~pwrite) ? rd : 32'h0;
        // Writes land at the completing edge; out-of-range select codes and polarity digits are ignored, other values are held at the limits
        if (wr) begin
            case (paddr)
                OFS_PULSE_SEL, OFS_A1_SEL, OFS_A2_SEL: begin
                    w = merge({27'h0, s.sel[paddr[3:2]]}, pwdata, pstrb);
                    if (w <= {27'h0, SRC_MAX}) begin
                        next_s.sel[paddr[3:2]] = w[4:0];
                    end
                end
                OFS_MAXF: begin
                    w = merge({18'h0, s.maxf}, pwdata, pstrb);
                    if (w < {18'h0, MAXF_MIN}) begin
                        next_s.maxf = MAXF_MIN;
                    end else if (w > {18'h0, MAXF_MAX}) begin
                        next_s.maxf = MAXF_MAX;
                    end else begin
                        next_s.maxf = w[13:0];
                    end
                end
                OFS_A1_OFF, OFS_A2_OFF: begin
                    w = merge(sext(s.off[paddr[3]]), pwdata, pstrb);
                    next_s.off[paddr[3]] = clamp_s(w[15:0], OFF_LIM);
                end
                OFS_A1_GAIN, OFS_A2_GAIN: begin
                    w = merge(sext(s.gain[paddr[3]]), pwdata, pstrb);
                    next_s.gain[paddr[3]] = clamp_s(w[15:0], GAIN_LIM);
                end
                OFS_POL: begin
                    w = merge(32'h0, pwdata, pstrb);
                    for (int i = 0; i < DOUT_N; i++) begin
                        // A digit other than 0 or 1 leaves that terminal as it was
                        if (pstrb[i/2] && w[POL_DIGIT_W*i +: POL_DIGIT_W] <= 4'h1) begin
                            next_s.pol[i] = w[POL_DIGIT_W*i];
                        end
                    end
                end
                default: begin
                    for (int i = 0; i < DOUT_N; i++) begin
                        if (paddr == OFS_DELAY0 + 12'(4 * i)) begin
                            w = merge({16'h0, s.delay[i]}, pwdata, pstrb);
                            next_s.delay[i] = (w > {16'h0, DELAY_MAX}) ? DELAY_MAX : w[15:0];
                        end
                    end
                end
            endcase
        end
        // Selected quantity per output, one cycle behind the inputs
        for (int i = 0; i < 3; i++) begin
            next_s.pct[i] = src[s.sel[i]];
        end
        // Frequency in 0.01 kHz steps between the floor and the set maximum
        span = (32'(s.pct[0]) * 32'(s.maxf - MAXF_MIN)) / PCT_SCALE;
        next_s.freq = MAXF_MIN + span[13:0];
        // Phase accumulator; a step of one unit gives a period of exactly 0.1 s
        sum = {1'b0, s.acc} + {11'h0, s.freq};
        if (sum >= {1'b0, NCO_MOD}) begin
            sum = sum - {1'b0, NCO_MOD};
        end
        next_s.acc = sum[23:0];
        next_s.pulse = (sum[23:0] < NCO_HALF);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.sel[0] <= PULSE_SEL_RST;
            s.sel[1] <= A1_SEL_RST;
            s.sel[2] <= A2_SEL_RST;
            s.maxf <= MAXF_RST;
            s.off <= {OFF_RST, OFF_RST};
            s.gain <= {GAIN_RST, GAIN_RST};
            s.delay <= {DELAY_RST, DELAY_RST, DELAY_RST, DELAY_RST, DELAY_RST};
            s.pol <= POL_RST;
            s.pct <= '0;
            s.freq <= MAXF_MIN;
            s.acc <= 24'h000000;
            s.pulse <= 1'b0;
            s.pready <= 1'b0;
            s.pslverr <= 1'b0;
            s.prdata <= 32'h0;
        end else begin
            s <= next_s;
        end
    end

    // Stage links
    assign bus.x = {s.pct[2], s.pct[1]};
    assign bus.gain = s.gain;
    assign bus.offset = s.off;
    assign bus.status = terminal_status;
    assign bus.polarity = s.pol;
    assign bus.delay = s.delay;

    otm_scale u_scale (
        .pclk(pclk),
        .presetn(presetn),
        .bus(bus.ana)
    );

    otm_dout #(
        .TICK(TICK_CYCLES)
    ) u_dout (
        .pclk(pclk),
        .presetn(presetn),
        .bus(bus.dig)
    );

    // Outputs, all from flops here or in the stages
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign pulse_freq_output = s.pulse;
    assign analog_out_1 = bus.y[0];
    assign analog_out_2 = bus.y[1];
    assign multi_terminal_digital_output = bus.terminal[0];
    assign relay_1_output = bus.terminal[1];
    assign relay_2_output = bus.terminal[2];
    assign digital_out_1 = bus.terminal[3];
    assign digital_out_2 = bus.terminal[4];
endmodule : otm_top

// ---- tb/otm_monitor.sv ----
// Port-level checks of the output terminal mapper
`timescale 1ns/1ps
module otm_monitor #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire otm_pkg::otm_word_t prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire otm_pkg::otm_pct_t analog_out_1,
    input wire otm_pkg::otm_pct_t analog_out_2
);
    import otm_pkg::*;
    // One clock domain, so one default clocking and reset
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (psel && !penable |=> pready && penable)
        else $error("no ready in access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (psel && !penable && paddr > OFS_ANA |=> pslverr)
        else $error("unmapped access not refused");
    a_err_misalign: assert property (psel && !penable && paddr[1:0] != 0 |=> pslverr)
        else $error("misaligned access not refused");
    a_ok_mapped: assert property (psel && !penable && paddr <= OFS_ANA && paddr[1:0] == 0
        |=> !pslverr) else $error("mapped access refused");
    a_rdata_idle: assert property (!pready |-> prdata == 0)
        else $error("read data outside access");
    a_clamp_one: assert property (analog_out_1 <= PCT_FULL)
        else $error("analog 1 beyond full scale");
    a_clamp_two: assert property (analog_out_2 <= PCT_FULL)
        else $error("analog 2 beyond full scale");
endmodule : otm_monitor

bind otm_top otm_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.pclk, .presetn, .psel,
    .penable, .paddr, .prdata, .pready, .pslverr, .analog_out_1, .analog_out_2);

// ---- tb/otm_meter.sv ----
// Frequency meter wired to the pulse output terminal
`timescale 1ns/1ps
module otm_meter (
    input wire logic pclk,
    input wire logic pulse,
    input wire logic clear,
    output int unsigned edges
);
    logic last;
    // Rising edges counted in the clock domain; pulse is registered, so no glitches
    always @(posedge pclk) begin
        last <= pulse;
        edges <= clear ? 0 : edges + 32'(pulse && !last);
    end
endmodule : otm_meter

// ---- tb/otm_top_tb.sv ----
// Register-level test of the output terminal mapper
`timescale 1ns/1ps
module otm_top_tb;
    import otm_pkg::*;
    localparam int CODES [12] = '{0, 1, 2, 3, 4, 5, 6, 10, 11, 12, 13, 16};
    localparam int PCTS [12] = '{500, 250, 500, 250, 1000, 500, 500, 500, 250, 250, 750, 250};
    localparam logic [11:0] RA [7] = '{OFS_PULSE_SEL, OFS_A2_SEL, OFS_MAXF, OFS_A1_GAIN,
        OFS_A1_OFF, OFS_DELAY0, OFS_POL};
    localparam int RV [7] = '{0, 1, 5000, 100, 0, 0, 0};
    localparam otm_word_t GN [3] = '{32'hffffffce, 32'h3e8, 32'hfffffc18};
    localparam int GE [3] = '{550, 1000, 0};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 1, er;
    logic [11:0] paddr = 0;
    otm_word_t pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, pulse;
    logic [4:0] st = 0;
    wire logic [4:0] term;
    otm_pct_t a1, a2;
    otm_qty_t q [25] = '{500, 250, 1000, 100, 100, 50, 100, 400, 100, 600, 1000, 5000, 0,
        0, 0, 30, 60, 1, 4, 250, 750, 1000, 0, 0, 16'hff9c};
    int unsigned edges, n_errors = 0, checked = 0;
    // Free-running 100 MHz clock
    always #5 pclk = ~pclk;
    otm_top #(.TICK_CYCLES(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .run_freq(q[0]), .set_freq(q[1]),
        .max_out_freq(q[2]), .out_current(q[3]), .rated_current(q[4]), .abs_torque(q[5]),
        .rated_torque(q[6]), .out_power(q[7]), .rated_power(q[8]), .out_voltage(q[9]),
        .rated_voltage(q[10]), .pulse_in_freq(q[11]), .analog_in_1(q[12]),
        .analog_in_2(q[13]), .analog_in_3(q[14]), .length_value(q[15]), .max_length(q[16]),
        .count_value(q[17]), .max_count(q[18]), .comm_permille(q[19]),
        .motor_speed(q[20]), .max_speed(q[21]), .current_deciamp(q[22]),
        .voltage_level(q[23]), .actual_torque(q[24]), .terminal_status(st),
        .pulse_freq_output(pulse), .analog_out_1(a1), .analog_out_2(a2),
        .multi_terminal_digital_output(term[0]), .relay_1_output(term[1]),
        .relay_2_output(term[2]), .digital_out_1(term[3]), .digital_out_2(term[4]));
    otm_meter u_meter (.pclk, .pulse, .clear(clr), .edges);

    task automatic check(input otm_word_t seen, input otm_word_t exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input otm_word_t d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // No wait-state count assumed; only the watchdog ends a stuck transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim

    // Hang guard, well beyond the roughly 20k cycles of the sequence
    initial begin
        #400us;
        n_errors++;
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        foreach (RA[i]) begin
            apb(0, RA[i], 0);
            check(rd, RV[i]);
        end
        apb(0, 12'h044, 0);
        check(32'(er), 1);
        check(32'(a2), 250);
        foreach (CODES[i]) begin
            apb(1, OFS_A1_SEL, CODES[i]);
            repeat (4) @(posedge pclk);
            check(32'(a1), PCTS[i]);
        end
        // Gain and offset on a half-scale source; large gains must saturate
        apb(1, OFS_A1_SEL, 0);
        apb(1, OFS_A1_OFF, 32'h320);
        foreach (GN[i]) begin
            apb(1, OFS_A1_GAIN, GN[i]);
            repeat (4) @(posedge pclk);
            check(32'(a1), GE[i]);
        end
        apb(0, OFS_FREQ, 0);
        check(rd, 2500);
        apb(1, OFS_MAXF, 0);
        apb(0, OFS_MAXF, 0);
        check(rd, 1);
        apb(0, OFS_FREQ, 0);
        check(rd, 1);
        apb(1, OFS_MAXF, 20000);
        apb(0, OFS_MAXF, 0);
        check(rd, 10000);
        q[0] <= 1000;
        clr <= 0;
        repeat (20000) @(posedge pclk);
        check(32'(edges >= 19 && edges <= 21), 1);
        st <= 5'h01;
        repeat (3) @(posedge pclk);
        check(32'(term), 32'h01);
        // Digit 2 in the units place is refused and keeps positive logic
        apb(1, OFS_POL, 32'h12);
        repeat (2) @(posedge pclk);
        check(32'(term), 32'h03);
        apb(1, OFS_DELAY0 + 12'h00c, 2);
        st <= 5'h09;
        repeat (10) @(posedge pclk);
        check(32'(term[3]), 0);
        repeat (30) @(posedge pclk);
        check(32'(term[3]), 1);
        // Return before expiry must restart the wait, not let the old one run on
        st <= 5'h01;
        repeat (15) @(posedge pclk);
        st <= 5'h09;
        repeat (1) @(posedge pclk);
        st <= 5'h01;
        repeat (14) @(posedge pclk);
        check(32'(term[3]), 1);
        repeat (10) @(posedge pclk);
        check(32'(term[3]), 0);
        end_sim();
    end
endmodule : otm_top_tb
